// ### core/acsa_pkg.sv
// Constants shared by the autoscan control and result memory arbiter
// Operation
// RL1: Control/status word answers at every even offset 0x0 to 0xE.
// RL2: Control word has exactly seven active bits out of sixteen.
// RL3: Software writes zero into the nine reserved control positions.
// RL4: Bits drive fail lamp, software reset and autoscan enable.
// RL5: One bit selects two's complement or offset binary results.
// RL6: Self-test bit has no effect, only echoes into status.
// RL7: Two-bit field selects how many channels the scan cycles through.
// RL8: Status read echoes control bits and adds calibration busy.
// RL9: Undefined status bits always read as zero.
// RL10: Scan and host take result memory one at a time.
// RL11: Host access delayed past sixteen clocks ends with retry.
// RL12: Host controller reissues a retried access until it completes.
// RL13: Memory arbitration never stretches or shifts the conversion schedule.
// RL14: When enabled, scan converts selected channels into memory continuously.
// RL15: Aggregate conversion rate is fixed at 99.5 kHz.
// RL16: Memory holds 32 words at 0x10-0x4E; lower 24 get results.
// RL17: Conversion is 10.05 us: 2.0 us sample, then 17 clocks.
// RL18: Mux advances at hold; prior result written during next conversion.
// RL19: Reset starts calibration, busy for 85,530 converter clocks.
// RL20: Same-cycle memory requests go to the scan side first.
// RL21: System reset clears all control bits to zero.
package acsa_pkg;
    // ****************************************************************
    // Address map (byte offsets on the add-on port)
    // ****************************************************************
    localparam logic [6:0] CSW_FIRST     = 7'h00;
    localparam logic [6:0] CSW_LAST      = 7'h0e;
    localparam logic [6:0] MEM_FIRST     = 7'h10;
    localparam logic [6:0] MEM_LAST      = 7'h4e;
    localparam int         MEM_WORDS     = 32;
    localparam int         SCAN_WORDS    = 24;
    // ****************************************************************
    // Control/status word fields
    // ****************************************************************
    localparam int          CTL_FAIL_OFF  = 0;
    localparam int          CTL_SOFT_RST  = 1;
    localparam int          CTL_SCAN_EN   = 2;
    localparam int          CTL_TWOS      = 3;
    localparam int          CTL_SELFTEST  = 4;
    localparam int          CTL_CHSEL_LO  = 5;
    localparam int          CTL_BITS      = 7;
    localparam int          STS_CAL_BUSY  = 7;
    localparam logic [15:0] CTL_RESET     = 16'h0000;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_MHZ        = 200;
    localparam int CONV_NS        = 10050;
    localparam int SAMPLE_NS      = 2000;
    localparam int CONV_CYC       = (CONV_NS * CLK_MHZ) / 1000;
    localparam int SAMPLE_CYC     = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
    localparam int ADC_PULSES     = 17;
    localparam int ADC_HALF_CYC   = 40;
    localparam int CAL_CLKS       = 85530;
    localparam int HOST_LIMIT_CLK = 16;
    localparam int ANSWER_LAT     = 2;
    localparam int RETRY_WAIT     = HOST_LIMIT_CLK - ANSWER_LAT;
    localparam int FIFO_DEPTH     = 16;

    typedef enum logic [2:0] {
        ST_CAL, ST_IDLE, ST_SAMPLE, ST_CONV, ST_WAIT
    } acsa_state_t;

    // Channels per scan for each select code
    function automatic logic [4:0] acsa_nchan(input logic [1:0] sel);
        case (sel)
            2'h0:    acsa_nchan = 5'd8;
            2'h1:    acsa_nchan = 5'd16;
            default: acsa_nchan = 5'd24;
        endcase
    endfunction : acsa_nchan
endpackage : acsa_pkg

// ### core/acsa_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module acsa_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] value_o
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, val_q;
    logic [WIDTH-1:0] val_d;

    always_comb begin
        // Accept only once the second and third stages agree
        val_d = (s2_q == s3_q) ? s3_q : val_q;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            val_q <= '0;
        end else begin
            s1_q  <= pin_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            val_q <= val_d;
        end
    end

    assign value_o = val_q;
endmodule : acsa_sync

// ### core/acsa_fifo.sv
// Result write buffer between scan sequencer and memory arbiter
`timescale 1ns/1ps
module acsa_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
        $error("acsa_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q, rd_q, wr_d, rd_d;
    logic             push, pop;

    always_comb begin
        in_ready_o  = (wr_q - rd_q) != (AW+1)'(DEPTH);
        out_valid_o = wr_q != rd_q;
        out_data_o  = mem_q[rd_q[AW-1:0]];
        push        = in_valid_i & in_ready_o;
        pop         = out_valid_o & out_ready_i;
        wr_d        = push ? wr_q + 1'b1 : wr_q;
        rd_d        = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end
endmodule : acsa_fifo

// ### core/acsa_top.sv
// Autoscan sequencer, control/status word and result memory arbiter
`timescale 1ns/1ps
module acsa_top
    import acsa_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_CLKS
) (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    // Add-on target port of the bus interface device
    input  wire logic        host_req_i,
    input  wire logic        host_we_i,
    input  wire logic [6:0]  host_addr_i,
    input  wire logic [15:0] host_wdata_i,
    output logic             host_ack_o,
    output logic             host_retry_o,
    output logic      [15:0] host_rdata_o,
    // Converter, multiplexer and lamp
    input  wire logic [15:0] adc_data_i,
    output logic             adc_sample_o,
    output logic             adc_clk_o,
    output logic             adc_cal_o,
    output logic      [4:0]  mux_addr_o,
    output logic             fail_led_off_o
);
    if (CAL_CYCLES < 1 || CAL_CYCLES > 131071) begin : g_bad_cal
        $error("acsa_top: CAL_CYCLES out of range");
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam int FW = 21;

    acsa_state_t      st_q, st_d;
    logic [11:0]      cnt_q, cnt_d;
    logic [7:0]       half_q, half_d;
    logic [4:0]       pulses_q, pulses_d;
    logic [16:0]      cal_cnt_q, cal_cnt_d;
    logic             clk_q, clk_d, smp_q, smp_d, cal_q, cal_d;
    logic [4:0]       chan_q, chan_d, mux_q, mux_d;
    logic             pend_q, pend_d;
    logic [4:0]       pend_ch_q, pend_ch_d;
    logic [15:0]      pend_dat_q, pend_dat_d;
    logic             push_q, push_d;
    logic [FW-1:0]    push_dat_q, push_dat_d;

    logic [CTL_BITS-1:0] ctrl_q, ctrl_d;
    logic             srst_q, srst_d, hdone_q, hdone_d, hbusy_q, hbusy_d;
    logic [4:0]       hwait_q, hwait_d;
    logic             ack_q, ack_d, retry_q, retry_d;
    logic [15:0]      rdata_q, rdata_d;
    logic [15:0]      mem_q [MEM_WORDS];
    logic [15:0]      mem_d [MEM_WORDS];

    logic [15:0]      adc_val;
    logic             fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [FW-1:0]    fifo_out_data;
    logic             scan_rst, half_end, rising, host_csw, host_mem;
    logic [4:0]       host_idx;

    function automatic logic [4:0] next_chan(input logic [4:0] c,
                                             input logic [1:0] sel);
        next_chan = (c >= acsa_nchan(sel) - 5'd1) ? 5'd0 : c + 5'd1;
    endfunction : next_chan

    // ****************************************************************
    // Converter data pin synchroniser and result buffer
    // ****************************************************************
    acsa_sync #(.WIDTH(16)) u_sync (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .pin_i     (adc_data_i),
        .value_o   (adc_val)
    );

    acsa_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (push_q),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_dat_q),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    // ****************************************************************
    // Scan sequencer
    // ****************************************************************
    always_comb begin
        scan_rst   = reset_i | srst_q;
        half_end   = half_q == 8'(ADC_HALF_CYC - 1);
        rising     = half_end & ~clk_q;
        st_d       = st_q;
        cnt_d      = cnt_q + 12'd1;
        half_d     = half_end ? 8'd0 : half_q + 8'd1;
        pulses_d   = pulses_q;
        cal_cnt_d  = cal_cnt_q;
        clk_d      = clk_q;
        smp_d      = smp_q;
        cal_d      = cal_q;
        chan_d     = chan_q;
        mux_d      = mux_q;
        pend_d     = pend_q;
        pend_ch_d  = pend_ch_q;
        pend_dat_d = pend_dat_q;
        // Held until the buffer takes it
        push_d     = push_q & ~fifo_in_ready;
        push_dat_d = push_dat_q;
        case (st_q)
            ST_CAL: begin
                // RL19 calibration clock count
                if (half_end) begin
                    clk_d = ~clk_q;
                end
                if (rising) begin
                    cal_cnt_d = cal_cnt_q - 17'd1;
                    if (cal_cnt_q == 17'd1) begin
                        st_d  = ST_IDLE;
                        cal_d = 1'b0;
                    end
                end
            end
            ST_IDLE: begin
                clk_d = 1'b0;
                mux_d = 5'd0;
                chan_d = 5'd0;
                // RL4 RL14 scan enable starts the loop
                if (ctrl_q[CTL_SCAN_EN]) begin
                    st_d  = ST_SAMPLE;
                    cnt_d = 12'd0;
                    smp_d = 1'b1;
                end
            end
            ST_SAMPLE: begin
                clk_d = 1'b0;
                // RL17 sample command length
                if (cnt_q == 12'(SAMPLE_CYC - 1)) begin
                    st_d     = ST_CONV;
                    smp_d    = 1'b0;
                    half_d   = 8'd0;
                    pulses_d = 5'd0;
                    // RL18 mux slews during hold
                    mux_d    = next_chan(chan_q, ctrl_q[CTL_CHSEL_LO +: 2]);
                    // RL18 previous result goes out now
                    if (pend_q) begin
                        push_d     = 1'b1;
                        push_dat_d = {pend_ch_q, pend_dat_q};
                        pend_d     = 1'b0;
                    end
                end
            end
            ST_CONV: begin
                if (half_end) begin
                    clk_d = ~clk_q;
                end
                // RL17 seventeen converter clocks
                if (rising) begin
                    pulses_d = pulses_q + 5'd1;
                    if (pulses_q == 5'(ADC_PULSES - 1)) begin
                        st_d = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                if (half_end) begin
                    clk_d = 1'b0;
                end
                // RL15 RL13 fixed period, never stretched
                if (cnt_q == 12'(CONV_CYC - 1)) begin
                    pend_ch_d  = chan_q;
                    // RL5 output format select
                    pend_dat_d = ctrl_q[CTL_TWOS] ?
                                 {~adc_val[15], adc_val[14:0]} : adc_val;
                    chan_d     = mux_q;
                    if (ctrl_q[CTL_SCAN_EN]) begin
                        st_d   = ST_SAMPLE;
                        cnt_d  = 12'd0;
                        smp_d  = 1'b1;
                        pend_d = 1'b1;
                    end else begin
                        // Last result is flushed when scanning stops
                        st_d       = ST_IDLE;
                        push_d     = 1'b1;
                        push_dat_d = {chan_q, pend_dat_d};
                    end
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (scan_rst) begin
            // RL19 calibration on any reset
            st_q      <= ST_CAL;
            cal_q     <= 1'b1;
            cal_cnt_q <= 17'(CAL_CYCLES);
            cnt_q     <= 12'd0;
            half_q    <= 8'd0;
            pulses_q  <= 5'd0;
            clk_q     <= 1'b0;
            smp_q     <= 1'b0;
            chan_q    <= 5'd0;
            mux_q     <= 5'd0;
            pend_q    <= 1'b0;
            push_q    <= 1'b0;
        end else begin
            st_q      <= st_d;
            cal_q     <= cal_d;
            cal_cnt_q <= cal_cnt_d;
            cnt_q     <= cnt_d;
            half_q    <= half_d;
            pulses_q  <= pulses_d;
            clk_q     <= clk_d;
            smp_q     <= smp_d;
            chan_q    <= chan_d;
            mux_q     <= mux_d;
            pend_q    <= pend_d;
            push_q    <= push_d;
        end
        pend_ch_q  <= pend_ch_d;
        pend_dat_q <= pend_dat_d;
        push_dat_q <= push_dat_d;
    end

    // ****************************************************************
    // Host port, control word and memory arbiter
    // ****************************************************************
    always_comb begin
        // RL1 all even offsets 0x0-0xE alias the word
        host_csw = host_addr_i <= CSW_LAST;
        // RL16 result memory window
        host_mem = host_addr_i >= MEM_FIRST && host_addr_i <= MEM_LAST;
        host_idx = 5'((host_addr_i - MEM_FIRST) >> 1);
        // RL10 one-cycle host hold blocks the buffer drain
        fifo_out_ready = ~hbusy_q;
        ack_d   = 1'b0;
        retry_d = 1'b0;
        rdata_d = rdata_q;
        ctrl_d  = ctrl_q;
        srst_d  = 1'b0;
        hdone_d = hdone_q;
        hbusy_d = 1'b0;
        hwait_d = hwait_q;
        mem_d   = mem_q;
        if (fifo_out_valid & fifo_out_ready) begin
            mem_d[fifo_out_data[20:16]] = fifo_out_data[15:0];
        end
        if (!host_req_i) begin
            hdone_d = 1'b0;
            hwait_d = 5'd0;
        end else if (!hdone_q) begin
            // RL20 pending scan write wins the memory
            if (!host_mem || (!fifo_out_valid && !hbusy_q)) begin
                ack_d   = 1'b1;
                hdone_d = 1'b1;
                hwait_d = 5'd0;
                hbusy_d = host_mem;
                rdata_d = 16'h0000;
                if (host_csw) begin
                    // RL8 RL9 status echo, unused bits zero
                    rdata_d[CTL_BITS-1:0] = ctrl_q;
                    rdata_d[STS_CAL_BUSY] = st_q == ST_CAL;
                end else if (host_mem) begin
                    rdata_d = mem_q[host_idx];
                end
                if (host_we_i && host_csw) begin
                    // RL2 RL6 RL7 only seven bits stored
                    ctrl_d = host_wdata_i[CTL_BITS-1:0];
                    // RL4 reset request is a self-clearing pulse
                    srst_d = host_wdata_i[CTL_SOFT_RST];
                    ctrl_d[CTL_SOFT_RST] = 1'b0;
                end else if (host_we_i && host_mem) begin
                    mem_d[host_idx] = host_wdata_i;
                end
            end else if (hwait_q == 5'(RETRY_WAIT - 1)) begin
                // RL11 give up before the sixteen-clock limit
                retry_d = 1'b1;
                hdone_d = 1'b1;
                hwait_d = 5'd0;
            end else begin
                hwait_d = hwait_q + 5'd1;
            end
        end
        if (srst_q) begin
            ctrl_d = CTL_RESET[CTL_BITS-1:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            // RL21 all control bits cleared after reset
            ctrl_q  <= CTL_RESET[CTL_BITS-1:0];
            srst_q  <= 1'b0;
            hdone_q <= 1'b0;
            hbusy_q <= 1'b0;
            hwait_q <= 5'd0;
            ack_q   <= 1'b0;
            retry_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            ctrl_q  <= ctrl_d;
            srst_q  <= srst_d;
            hdone_q <= hdone_d;
            hbusy_q <= hbusy_d;
            hwait_q <= hwait_d;
            ack_q   <= ack_d;
            retry_q <= retry_d;
            rdata_q <= rdata_d;
        end
        mem_q <= mem_d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign host_ack_o     = ack_q;
    assign host_retry_o   = retry_q;
    assign host_rdata_o   = rdata_q;
    assign adc_sample_o   = smp_q;
    assign adc_clk_o      = clk_q;
    assign adc_cal_o      = cal_q;
    assign mux_addr_o     = mux_q;
    assign fail_led_off_o = ctrl_q[CTL_FAIL_OFF];
endmodule : acsa_top

// ### tb/acsa_props.sv
// Port-level assertions for the autoscan block
`timescale 1ns/1ps
module acsa_props #(
    parameter int CAL_CYCLES = 4
) (
    input logic        sys_clk_i,
    input logic        reset_i,
    input logic        host_req_i,
    input logic        host_we_i,
    input logic [6:0]  host_addr_i,
    input logic [15:0] host_wdata_i,
    input logic        host_ack_o,
    input logic        host_retry_o,
    input logic [15:0] host_rdata_o,
    input logic [15:0] adc_data_i,
    input logic        adc_sample_o,
    input logic        adc_clk_o,
    input logic        adc_cal_o,
    input logic [4:0]  mux_addr_o,
    input logic        fail_led_off_o
);
    // ****************************************************************
    // Helper counters
    // ****************************************************************
    localparam int CAL_LEN = CAL_CYCLES * 80 - 40; // Ends on last rise
    int   w_cnt;
    int   smp_len;
    int   per_cnt;
    int   pls_cnt;
    int   cal_cnt;
    logic seen_q;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    always_ff @(posedge sys_clk_i) begin
        w_cnt <= (reset_i || !host_req_i || host_ack_o || host_retry_o)
                 ? 0 : w_cnt + 1;
        per_cnt <= $rose(adc_sample_o) ? 1 : per_cnt + 1;
        smp_len <= adc_sample_o ? smp_len + 1 : 0;
        cal_cnt <= (reset_i || !adc_cal_o) ? 0 : cal_cnt + 1;
        if (reset_i || adc_cal_o) begin
            seen_q <= 1'b0;
        end else if ($rose(adc_sample_o)) begin
            seen_q <= 1'b1;
        end
        if ($fell(adc_sample_o)) begin
            pls_cnt <= 0;
        end else if ($rose(adc_clk_o)) begin
            pls_cnt <= pls_cnt + 1;
        end
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    sequence s_hold_start;
        adc_sample_o ##1 !adc_sample_o;
    endsequence
    property p_one_answer;
        !(host_ack_o && host_retry_o);
    endproperty
    property p_answer_bound;
        $rose(host_req_i) |-> ##[1:15] (host_ack_o || host_retry_o);
    endproperty
    property p_wait_limit;
        host_req_i |-> w_cnt < 16;
    endproperty
    property p_sample_len;
        s_hold_start |-> smp_len == 400;
    endproperty
    property p_clk_idle;
        adc_sample_o |-> !adc_clk_o;
    endproperty
    property p_period;
        $rose(adc_sample_o) && seen_q |-> per_cnt == 2010;
    endproperty
    property p_pulses;
        $rose(adc_sample_o) && seen_q |-> pls_cnt == 17;
    endproperty
    property p_mux_step;
        $fell(adc_sample_o) |-> ##[0:2] $changed(mux_addr_o);
    endproperty
    property p_mux_range;
        mux_addr_o < 5'h18;
    endproperty
    property p_cal_start;
        $fell(reset_i) |-> adc_cal_o;
    endproperty
    property p_cal_len;
        $fell(adc_cal_o) |-> cal_cnt >= CAL_LEN - 2 && cal_cnt <= CAL_LEN + 2;
    endproperty
    a_one_answer: assert property (p_one_answer)
        else $error("ack and retry together");
    a_answer_bound: assert property (p_answer_bound)
        else $error("host access not answered in time");
    a_wait_limit: assert property (p_wait_limit)
        else $error("host access held past sixteen clocks");
    a_sample_len: assert property (p_sample_len)
        else $error("sample command length wrong");
    a_clk_idle: assert property (p_clk_idle)
        else $error("converter clock active during sample");
    a_period: assert property (p_period)
        else $error("conversion period wrong");
    a_pulses: assert property (p_pulses)
        else $error("converter clock pulse count wrong");
    a_mux_step: assert property (p_mux_step)
        else $error("mux did not advance at hold");
    a_mux_range: assert property (p_mux_range)
        else $error("mux channel out of range");
    a_cal_start: assert property (p_cal_start)
        else $error("calibration not asserted after reset");
    a_cal_len: assert property (p_cal_len)
        else $error("calibration length wrong");
endmodule : acsa_props
bind acsa_top acsa_props #(.CAL_CYCLES(CAL_CYCLES)) acsa_props_i (.*);

// ### tb/acsa_host_model.sv
// Host bus controller model issuing target accesses
`timescale 1ns/1ps
module acsa_host_model (
    input  logic        sys_clk_i,
    input  logic        host_ack_i,
    input  logic        host_retry_i,
    input  logic [15:0] host_rdata_i,
    output logic        host_req_o,
    output logic        host_we_o,
    output logic [6:0]  host_addr_o,
    output logic [15:0] host_wdata_o
);
    initial begin
        host_req_o   = 1'b0;
        host_we_o    = 1'b0;
        host_addr_o  = 7'h7f;
        host_wdata_o = 16'hffff;
    end
    task automatic access(input logic we, input logic [6:0] addr,
                          input logic [15:0] wdata,
                          output logic [15:0] rdata, output logic ok);
        logic done;
        done  = 1'b0;
        rdata = 16'h0000;
        while (!done) begin
            @(posedge sys_clk_i);
            host_req_o   <= 1'b1;
            host_we_o    <= we;
            host_addr_o  <= addr;
            host_wdata_o <= wdata;
            do @(posedge sys_clk_i);
            while (host_ack_i !== 1'b1 && host_retry_i !== 1'b1);
            done  = host_ack_i;
            rdata = host_rdata_i;
            // Released request, address and data lines must not keep the old value; write enable keeps it
            host_req_o   <= 1'b0;
            host_addr_o  <= ~addr;
            host_wdata_o <= ~wdata;
        end
        ok = done;
    endtask : access
endmodule : acsa_host_model

// ### tb/tb_top.sv
// Self-checking bench for the autoscan block
`timescale 1ns/1ps
module tb_top;
    import acsa_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic host_req_i, host_we_i, host_ack_o, host_retry_o;
    logic [6:0] host_addr_i;
    logic [15:0] host_wdata_i, host_rdata_o;
    logic [15:0] adc_data_i = 16'h8005;
    logic adc_sample_o, adc_clk_o, adc_cal_o, fail_led_off_o;
    logic [4:0] mux_addr_o;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    acsa_top #(.CAL_CYCLES(4)) acsa_top_i (.*);
    acsa_host_model acsa_host_model_i (
        .sys_clk_i(sys_clk_i), .host_ack_i(host_ack_o),
        .host_retry_i(host_retry_o), .host_rdata_i(host_rdata_o),
        .host_req_o(host_req_i), .host_we_o(host_we_i),
        .host_addr_o(host_addr_i), .host_wdata_o(host_wdata_i));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic tally_and_finish;
        if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic ok;
        acsa_host_model_i.access(1'b1, a, d, q, ok);
        chk("write done", 16'h0001, {15'h0000, ok});
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [15:0] exp,
                      input string what);
        logic [15:0] q;
        logic ok;
        acsa_host_model_i.access(1'b0, a, 16'h0000, q, ok);
        chk(what, exp, q);
    endtask : rd
    task automatic wait_cal;
        int n;
        n = 0;
        while (adc_cal_o !== 1'b0 && n < 2000) begin
            @(posedge sys_clk_i);
            n++;
        end
        chk("calibration ends", 16'h0000, {15'h0000, adc_cal_o});
    endtask : wait_cal
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset_state;
        rd(7'h00, 16'h0080, "status after reset");
        chk("lamp after reset", 16'h0000, {15'h0, fail_led_off_o});
        wait_cal();
    endtask : t_reset_state
    task automatic t_csw;
        logic [15:0] v[8] = '{16'h0001, 16'h0008, 16'h0010, 16'h0020,
                              16'h0040, 16'h0060, 16'h0079, 16'h0000};
        for (int i = 0; i < 8; i++) begin
            wr(7'(2 * i), v[i]);
            rd(7'(2 * ((i + 3) % 8)), v[i], "status echo");
            chk("lamp bit", {15'h0, v[i][0]}, {15'h0, fail_led_off_o});
            chk("self-test inert", 16'h0000, {15'h0, adc_sample_o});
        end
        wr(7'h50, 16'hffff);
        rd(7'h50, 16'h0000, "unmapped read");
        rd(7'h0e, 16'h0000, "status unchanged");
    endtask : t_csw
    task automatic t_mem;
        for (int i = 0; i < MEM_WORDS; i++) wr(7'(MEM_FIRST + 2 * i),
                                               16'ha500 | 16'(i));
        for (int i = 0; i < MEM_WORDS; i++) rd(7'(MEM_FIRST + 2 * i),
                                    16'ha500 | 16'(i), "memory word");
    endtask : t_mem
    task automatic t_soft;
        wr(7'h00, 16'h0013);
        rd(7'h00, 16'h0080, "status after soft reset");
        chk("calibration restarts", 16'h0001, {15'h0, adc_cal_o});
        chk("lamp after soft reset", 16'h0000, {15'h0, fail_led_off_o});
        wait_cal();
    endtask : t_soft
    task automatic t_scan;
        wr(7'h00, 16'h000c);
        for (int i = 0; i < 40; i++) begin
            repeat (500) @(posedge sys_clk_i);
            rd(7'(MEM_FIRST + 16), 16'ha508, "slot outside scan");
        end
        for (int i = 0; i < 8; i++) rd(7'(MEM_FIRST + 2 * i), 16'h0005,
                                       "scan result");
        rd(7'h08, 16'h000c, "status while scanning");
    endtask : t_scan
    // ****************************************************************
    // Main sequence and timeout
    // ****************************************************************
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        t_reset_state();
        t_csw();
        t_mem();
        t_soft();
        t_scan();
        tally_and_finish();
    end
endmodule : tb_top
